// ### hdl/printer_option_switch_decoder.v
// Option switch decoder, factory restore sequencer and LED driver.
`timescale 1ns/1ps
`default_nettype none
`include "option_decoder_regs.vh"
module printer_option_switch_decoder
#(
    parameter IS_ETHERNET = 1'b1,
    parameter CNT_W = 32,
    parameter [CNT_W-1:0] HOLD_MIN_CYCLES = `HOLD_MIN_CYCLES,
    parameter [CNT_W-1:0] HOLD_MAX_CYCLES = `HOLD_MAX_CYCLES,
    parameter [`DEBOUNCE_W-1:0] DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES,
    parameter [CNT_W-1:0] FLASH_CYCLES = `FLASH_CYCLES,
    parameter [CNT_W-1:0] PULSE_CYCLES = `PULSE_CYCLES
)
(
    input wire ref_clk,
    input wire arst_n,
    input wire [7:0] option_bank_one,
    input wire [3:0] option_bank_two,
    input wire push_switch,
    input wire offline,
    input wire rx_buffer_full,
    input wire status_changed,
    input wire reverse_feed_entered,
    input wire link_100base_tx,
    input wire packet_received,
    output reg line_mode,
    output reg dpi_203,
    output reg sensor_enable,
    output reg usb_printer_class,
    output reg auto_status_report_en,
    output reg reverse_feed_status_en,
    output reg busy,
    output reg send_status,
    output reg factory_restore,
    output reg reboot_request,
    output reg pending_init,
    output reg led_green,
    output reg led_red
);
    localparam ST_NORMAL = 2'd0;
    localparam ST_PENDING = 2'd1;
    localparam ST_RESTORE = 2'd2;
    localparam ST_REBOOT = 2'd3;

    reg [7:0] bank_one;
    reg [3:0] bank_two;
    reg sampled;
    reg [1:0] state;
    reg [CNT_W-1:0] hold_count;
    reg [CNT_W-1:0] flash_count;
    reg [CNT_W-1:0] red_count;
    reg flash_phase;
    reg press_prev;
    wire press;
    wire release_edge;
    wire hold_ok;

    switch_debouncer #(.COUNT_W(`DEBOUNCE_W),
        .STABLE_CYCLES(DEBOUNCE_CYCLES))
        u_debounce
    (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .raw_in(push_switch),
        .clean(press)
    );

    assign release_edge = press_prev & ~press;
    assign hold_ok = (hold_count >= HOLD_MIN_CYCLES) &&
                     (hold_count <= HOLD_MAX_CYCLES);

    // Switches read as 1 when on; reset values equal all-on defaults.
    // They are caught once after reset so a switch moved while running
    // cannot change behaviour mid-job; a reboot takes a fresh sample.
    always @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bank_one <= `BANK_ONE_RESET;
            bank_two <= `BANK_TWO_RESET;
            sampled <= 1'b0;
        end
        else if (!sampled)
        begin
            bank_one <= option_bank_one;
            bank_two <= option_bank_two;
            sampled <= 1'b1;
        end
        else if (state == ST_REBOOT)
        begin
            sampled <= 1'b0;
        end
    end

    // Reserved switches, bank two among them, are ignored; they must
    // stay on and no behaviour is defined for them.
    always @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            line_mode <= 1'b1;
            dpi_203 <= 1'b1;
            sensor_enable <= 1'b0;
            usb_printer_class <= 1'b1;
            auto_status_report_en <= 1'b1;
            reverse_feed_status_en <= 1'b1;
        end
        else
        begin
            line_mode <= bank_one[`SW_EMULATION];
            dpi_203 <= bank_one[`SW_EMULATION] |
                       bank_one[`SW_DPI];
            sensor_enable <= ~bank_one[`SW_SENSOR];
            usb_printer_class <= IS_ETHERNET ? 1'b0 :
                                 bank_one[`SW_USB_CLASS];
            // Printer class and Ethernet enable with switch on.
            auto_status_report_en <= (IS_ETHERNET ||
                bank_one[`SW_USB_CLASS]) ? bank_one[`SW_AUTO_STATUS] :
                ~bank_one[`SW_AUTO_STATUS];
            reverse_feed_status_en <= bank_one[`SW_EMULATION] &
                ((IS_ETHERNET || bank_one[`SW_USB_CLASS]) ?
                bank_one[`SW_REVERSE_FEED] :
                ~bank_one[`SW_REVERSE_FEED]);
        end
    end

    always @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            busy <= 1'b0;
            send_status <= 1'b0;
        end
        else
        begin
            busy <= rx_buffer_full |
                    (bank_one[`SW_BUSY_COND] & offline);
            send_status <= (auto_status_report_en & status_changed) |
                (reverse_feed_status_en &
                 reverse_feed_entered);
        end
    end

    always @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= ST_NORMAL;
            press_prev <= 1'b0;
            hold_count <= {CNT_W{1'b0}};
            factory_restore <= 1'b0;
            reboot_request <= 1'b0;
        end
        else
        begin
            press_prev <= press;
            factory_restore <= 1'b0;
            reboot_request <= 1'b0;
            if (!press)
                hold_count <= {CNT_W{1'b0}};
            else if (hold_count != {CNT_W{1'b1}})
                hold_count <= hold_count + 1'b1;
            case (state)
                ST_NORMAL:
                begin
                    if (IS_ETHERNET && release_edge && hold_ok)
                        state <= ST_PENDING;
                end
                ST_PENDING:
                begin
                    if (release_edge)
                        state <= ST_RESTORE;
                end
                ST_RESTORE:
                begin
                    factory_restore <= 1'b1;
                    state <= ST_REBOOT;
                end
                ST_REBOOT:
                begin
                    reboot_request <= 1'b1;
                    state <= ST_NORMAL;
                end
                default:
                begin
                    state <= ST_NORMAL;
                end
            endcase
        end
    end

    // Red LED stretches each packet so that short bursts stay visible.
    always @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            flash_count <= {CNT_W{1'b0}};
            flash_phase <= 1'b0;
            red_count <= {CNT_W{1'b0}};
            pending_init <= 1'b0;
            led_green <= 1'b0;
            led_red <= 1'b0;
        end
        else
        begin
            pending_init <= (state == ST_PENDING);
            if (state != ST_PENDING || flash_count == FLASH_CYCLES - 1'b1)
                flash_count <= {CNT_W{1'b0}};
            else
                flash_count <= flash_count + 1'b1;
            if (state != ST_PENDING)
                flash_phase <= 1'b1;
            else if (flash_count == FLASH_CYCLES - 1'b1)
                flash_phase <= ~flash_phase;
            if (packet_received)
                red_count <= PULSE_CYCLES;
            else if (red_count != {CNT_W{1'b0}})
                red_count <= red_count - 1'b1;
            if (state == ST_PENDING)
            begin
                led_green <= flash_phase;
                led_red <= flash_phase;
            end
            else if (state != ST_NORMAL)
            begin
                led_green <= 1'b0;
                led_red <= 1'b0;
            end
            else
            begin
                led_green <= link_100base_tx;
                led_red <= packet_received |
                           (red_count != {CNT_W{1'b0}});
            end
        end
    end
endmodule
`default_nettype wire

// ### hdl/option_decoder_regs.vh
// Constants for the option switch decoder and push switch timing.
`ifndef OPTION_DECODER_REGS_VH
`define OPTION_DECODER_REGS_VH
`define SW_EMULATION 0
`define SW_DPI 1
`define SW_SENSOR 3
`define SW_USB_CLASS 4
`define SW_BUSY_COND 5
`define SW_AUTO_STATUS 6
`define SW_REVERSE_FEED 7
`define BANK_ONE_RESET 8'hFF
`define BANK_TWO_RESET 4'hF
// Cycle counts at the 5 ns clock: one and five seconds of hold, a 10 ms
// debounce window, a 250 ms flash half period and a 50 ms red pulse.
`define HOLD_MIN_CYCLES 32'h0BEB_C200
`define HOLD_MAX_CYCLES 32'h3B9A_CA00
`define DEBOUNCE_W 22
`define DEBOUNCE_CYCLES 22'h1E_8480
`define FLASH_CYCLES 32'h02FA_F080
`define PULSE_CYCLES 32'h0098_9680
`endif

// ### hdl/switch_debouncer.v
// Debounce filter for the push switch.
`timescale 1ns/1ps
`default_nettype none
module switch_debouncer
#(
    parameter COUNT_W = 22,
    parameter [COUNT_W-1:0] STABLE_CYCLES = 22'h1E_8480
)
(
    input wire ref_clk,
    input wire arst_n,
    input wire raw_in,
    output reg clean
);
    reg [COUNT_W-1:0] count;
    // A new level is accepted only after it has held for the full window.
    always @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            clean <= 1'b0;
            count <= {COUNT_W{1'b0}};
        end
        else if (raw_in == clean)
        begin
            count <= {COUNT_W{1'b0}};
        end
        else if (count == STABLE_CYCLES - 1'b1)
        begin
            clean <= raw_in;
            count <= {COUNT_W{1'b0}};
        end
        else
        begin
            count <= count + 1'b1;
        end
    end
endmodule
`default_nettype wire

// ### testbench/option_decoder_asserts.sv
// Checker for the option switch decoder, bound to its ports.
`timescale 1ns/1ps
`default_nettype none
module option_decoder_asserts (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic rx_buffer_full,
    input wire logic status_changed,
    input wire logic reverse_feed_entered,
    input wire logic link_100base_tx,
    input wire logic packet_received,
    input wire logic line_mode,
    input wire logic auto_status_report_en,
    input wire logic busy,
    input wire logic send_status,
    input wire logic factory_restore,
    input wire logic reboot_request,
    input wire logic pending_init,
    input wire logic led_green,
    input wire logic led_red
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // Settings are still settling for a few edges after reset or reboot.
    logic [1:0] settle;
    always_ff @(posedge ref_clk or negedge arst_n)
        if (!arst_n)
            settle <= 2'h0;
        else if (reboot_request)
            settle <= 2'h0;
        else if (settle != 2'h3)
            settle <= settle + 2'h1;
    a_busy_full: assert property (rx_buffer_full |=> busy)
        else $error("busy missing while buffer full");
    a_status_sent: assert property (
        status_changed && auto_status_report_en |=> send_status)
        else $error("status report missing");
    a_status_quiet: assert property (!status_changed &&
        !reverse_feed_entered |=> !send_status) else $error("stray report");
    a_restore_reboot: assert property (factory_restore
        |=> reboot_request && !led_green && !led_red)
        else $error("reboot or led off missing after restore");
    a_restore_pending: assert property (factory_restore
        |-> $past(pending_init)) else $error("restore outside pending");
    a_green_link: assert property (
        (link_100base_tx && !pending_init && !factory_restore &&
        !reboot_request)[*3] |-> led_green)
        else $error("green led dark on fast link");
    a_red_packet: assert property (
        packet_received && !pending_init && !factory_restore |=> led_red)
        else $error("red led dark");
    a_settings_hold: assert property (settle == 2'h3 &&
        !reboot_request |=> $stable(line_mode)) else $error("setting moved");
endmodule
`default_nettype wire

// ### testbench/host_model.sv
// Host side model: link partner that sends packets and counts reports.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic ref_clk,
    input wire logic send_status,
    output logic link_100base_tx,
    output logic packet_received
);
    int reports = 0;
    initial link_100base_tx = 1'b0;
    initial packet_received = 1'b0;
    always @(posedge ref_clk)
        if (send_status)
            reports <= reports + 1;
    task automatic set_link(input logic v);
        @(posedge ref_clk);
        link_100base_tx <= v;
    endtask
    task automatic send_packet();
        @(posedge ref_clk);
        packet_received <= 1'b1;
        @(posedge ref_clk);
        packet_received <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ### testbench/printer_option_switch_decoder_tb_top.sv
// Self-checking bench for the option switch decoder, Ethernet variant.
`timescale 1ns/1ps
`default_nettype none
module printer_option_switch_decoder_tb_top;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] bank1 = 8'hFF;
    // Bank two is reserved and the operator keeps it all on.
    logic [3:0] bank2 = 4'hF;
    logic push = 1'b0, offline = 1'b0, full = 1'b0, chg = 1'b0, rev = 1'b0;
    wire link, pkt, line_mode, dpi, sensor, usb, auto_en, rev_en, busy;
    wire send, restore, reboot, pend, led_g, led_r;
    int n_fail = 0, checks_done = 0, cycles = 0, ones = 0, k = 0;
    initial forever #2.5 ref_clk = ~ref_clk;
    // Counts are shortened so the hold windows fit a short run.
    printer_option_switch_decoder #(
        .HOLD_MIN_CYCLES(32'h14), .HOLD_MAX_CYCLES(32'h64),
        .DEBOUNCE_CYCLES(22'h4), .FLASH_CYCLES(32'h8),
        .PULSE_CYCLES(32'h8)) dut_u (
        .ref_clk(ref_clk), .arst_n(arst_n), .option_bank_one(bank1),
        .option_bank_two(bank2), .push_switch(push), .offline(offline),
        .rx_buffer_full(full), .status_changed(chg),
        .reverse_feed_entered(rev), .link_100base_tx(link),
        .packet_received(pkt), .line_mode(line_mode), .dpi_203(dpi),
        .sensor_enable(sensor), .usb_printer_class(usb),
        .auto_status_report_en(auto_en), .reverse_feed_status_en(rev_en),
        .busy(busy), .send_status(send), .factory_restore(restore),
        .reboot_request(reboot), .pending_init(pend), .led_green(led_g),
        .led_red(led_r));
    host_model host_u (.ref_clk(ref_clk), .send_status(send),
        .link_100base_tx(link), .packet_received(pkt));
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic check(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic do_reset(input logic [7:0] b);
        @(posedge ref_clk);
        arst_n <= 1'b0;
        bank1 <= b;
        repeat (3) @(posedge ref_clk);
        arst_n <= 1'b1;
        tick(5);
    endtask
    task automatic press(input int n);
        @(posedge ref_clk);
        push <= 1'b1;
        repeat (n) @(posedge ref_clk);
        push <= 1'b0;
        tick(12);
    endtask
    task automatic events();
        @(posedge ref_clk);
        chg <= 1'b1;
        @(posedge ref_clk);
        chg <= 1'b0;
        rev <= 1'b1;
        @(posedge ref_clk);
        rev <= 1'b0;
        tick(3);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            n_fail++;
            end_sim();
        end
    end
    initial
    begin
        do_reset(8'hFF);
        check("line_mode", 1'b1, line_mode);
        check("dpi_203", 1'b1, dpi);
        check("sensor", 1'b0, sensor);
        check("usb_class", 1'b0, usb);
        check("auto_en", 1'b1, auto_en);
        check("rev_en", 1'b1, rev_en);
        @(posedge ref_clk);
        offline <= 1'b1;
        tick(2);
        check("busy_offline", 1'b1, busy);
        events();
        check("reports", 1'b1, host_u.reports == 2);
        $display("test defaults done");
        do_reset(8'h94);
        check("line_mode", 1'b0, line_mode);
        check("sensor_on", 1'b1, sensor);
        check("dpi_180", 1'b0, dpi);
        check("auto_off", 1'b0, auto_en);
        check("rev_off", 1'b0, rev_en);
        check("busy_offline", 1'b0, busy);
        @(posedge ref_clk);
        full <= 1'b1;
        tick(2);
        check("busy_full", 1'b1, busy);
        @(posedge ref_clk);
        full <= 1'b0;
        events();
        check("no_reports", 1'b1, host_u.reports == 2);
        @(posedge ref_clk);
        bank1 <= 8'hFF;
        tick(4);
        check("held", 1'b0, line_mode);
        $display("test alternate done");
        press(10);
        check("short_press", 1'b0, pend);
        press(120);
        check("long_press", 1'b0, pend);
        press(50);
        check("pending", 1'b1, pend);
        repeat (20)
        begin
            tick(1);
            ones += led_g;
        end
        check("flash", 1'b1, ones > 0 && ones < 20);
        @(posedge ref_clk);
        push <= 1'b1;
        repeat (10) @(posedge ref_clk);
        push <= 1'b0;
        while (restore !== 1'b1 && k < 40)
        begin
            tick(1);
            k++;
        end
        check("restore", 1'b1, restore);
        tick(1);
        check("reboot", 1'b1, reboot);
        check("leds_off", 1'b0, led_g | led_r);
        tick(5);
        check("resampled", 1'b1, line_mode);
        $display("test restore done");
        host_u.set_link(1'b1);
        tick(4);
        check("green_on", 1'b1, led_g);
        host_u.send_packet();
        tick(1);
        check("red_on", 1'b1, led_r);
        host_u.set_link(1'b0);
        tick(4);
        check("green_off", 1'b0, led_g);
        $display("test leds done");
        end_sim();
    end
endmodule
bind printer_option_switch_decoder option_decoder_asserts chk_u (.*);
`default_nettype wire
